// ==== hw/ssod_pkg.sv ====
package ssod_pkg;

  localparam int DATA_W    = 16;
  localparam int COUNT_W   = 5;
  localparam int SIGN_BIT  = 15;
  localparam int MAX_DSHIFT = 31;

  localparam logic [15:0] ACC_RST   = 16'h0000;
  localparam logic [15:0] Q_RST     = 16'h0000;
  localparam logic [15:0] WDATA_RST = 16'h0000;
  localparam logic [15:0] POS_ZERO  = 16'h0000;
  localparam logic [15:0] WORD_ONE  = 16'h0001;
  localparam logic        OVF_RST   = 1'b0;

  typedef enum logic [4:0] {
    OP_NOP                 = 5'h00,
    OP_ENTER_ACC_IMMEDIATE = 5'h01,
    OP_ENTER_Q_IMMEDIATE   = 5'h02,
    OP_LOAD_ACC            = 5'h03,
    OP_LOAD_Q              = 5'h04,
    OP_STORE_Q             = 5'h05,
    OP_AND_ACC             = 5'h06,
    OP_ADD_ACC             = 5'h07,
    OP_SUB_ACC             = 5'h08,
    OP_ADD_TO_Q            = 5'h09,
    OP_INCREASE_ACC        = 5'h0a,
    OP_INCREASE_Q          = 5'h0b,
    OP_REPLACE_ADD_ONE     = 5'h0c,
    OP_EXCLUSIVE_OR_ACC    = 5'h0d,
    OP_SKIP_ACC_POS_ZERO   = 5'h0e,
    OP_SKIP_ACC_NONZERO    = 5'h0f,
    OP_SKIP_ACC_POSITIVE   = 5'h10,
    OP_SKIP_ACC_NEGATIVE   = 5'h11,
    OP_SKIP_Q_POS_ZERO     = 5'h12,
    OP_SKIP_Q_NONZERO      = 5'h13,
    OP_SKIP_Q_POSITIVE     = 5'h14,
    OP_SKIP_Q_NEGATIVE     = 5'h15,
    OP_SKIP_ON_OVERFLOW    = 5'h16,
    OP_SKIP_ON_NO_OVERFLOW = 5'h17,
    OP_SHIFT_ACC_LEFT      = 5'h18,
    OP_SHIFT_ACC_RIGHT     = 5'h19,
    OP_SHIFT_Q_LEFT        = 5'h1a,
    OP_SHIFT_Q_RIGHT       = 5'h1b,
    OP_SHIFT_LONG_LEFT     = 5'h1c,
    OP_SHIFT_LONG_RIGHT    = 5'h1d
  } ssod_op_t;

  typedef struct packed {
    ssod_op_t     op;
    logic [15:0]  operand;
    logic [4:0]   count;
  } ssod_instr_t;

endpackage : ssod_pkg

// ==== hw/ssod_oc_adder.sv ====
`timescale 1ns/100ps
module ssod_oc_adder #(
  parameter int WIDTH = 16
) (
  // operands
  input  wire logic [WIDTH-1:0] x,
  input  wire logic [WIDTH-1:0] y,
  // result
  output logic      [WIDTH-1:0] sum,
  output logic                  ovf
);

  generate
    if (WIDTH < 2)
    begin : g_bad
      $error("ssod_oc_adder: WIDTH must be at least 2");
    end
  endgenerate

  logic [WIDTH:0] raw;

  // end-around carry keeps the sum in one's complement
  always_comb
  begin
    raw = {1'b0, x} + {1'b0, y};
    sum = raw[WIDTH-1:0] + {{(WIDTH-1){1'b0}}, raw[WIDTH]};
    // like signs giving an unlike sign means overflow
    ovf = (x[WIDTH-1] == y[WIDTH-1]) && (sum[WIDTH-1] != x[WIDTH-1]);
  end

endmodule : ssod_oc_adder

// ==== hw/ssod_shifter.sv ====
`timescale 1ns/100ps
module ssod_shifter #(
  parameter int WIDTH   = 16,
  parameter int COUNT_W = 5
) (
  // request
  input  wire logic [WIDTH-1:0]   value,
  input  wire logic [COUNT_W-1:0] count,
  input  wire logic               left,
  // result
  output logic      [WIDTH-1:0]   result
);

  generate
    if (WIDTH < 2 || COUNT_W < 1)
    begin : g_bad
      $error("ssod_shifter: WIDTH or COUNT_W out of range");
    end
  endgenerate

  // left is end-around so no bit is lost; right copies the sign
  always_comb
  begin
    result = value;
    for (int i = 0; i < (1 << COUNT_W) - 1; i++)
    begin
      if (i < int'(count))
      begin
        if (left)
          result = {result[WIDTH-2:0], result[WIDTH-1]};
        else
          result = {result[WIDTH-1], result[WIDTH-1:1]};
      end
    end
  end

endmodule : ssod_shifter

// ==== hw/ssod_datapath.sv ====
`timescale 1ns/100ps
module ssod_datapath (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rstn,
  // instruction
  input  wire logic                op_valid,
  input  wire ssod_pkg::ssod_instr_t instr,
  // register state
  output logic [15:0]              acc_reg,
  output logic [15:0]              q_reg,
  output logic                     overflow_reg,
  // sequencing
  output logic                     skip_reg,
  output logic                     done_reg,
  // memory write
  output logic                     mem_wr_reg,
  output logic [15:0]              mem_wdata_reg
);

  logic [15:0] acc_next;
  logic [15:0] q_next;
  logic        overflow_next;
  logic        skip_next;
  logic        done_next;
  logic        mem_wr_next;
  logic [15:0] mem_wdata_next;
  logic [15:0] add_x;
  logic [15:0] add_y;
  logic [15:0] add_sum;
  logic        add_ovf;
  logic [15:0] sh_a_res;
  logic [15:0] sh_q_res;
  logic [31:0] sh_aq_res;
  logic        sh_left;
  ssod_pkg::ssod_op_t op;
  logic [15:0] opnd;

  assign op   = instr.op;
  assign opnd = instr.operand;

  // operand selection for the one shared adder
  always_comb
  begin
    add_x = acc_reg;
    add_y = opnd;
    case (op)
      ssod_pkg::OP_SUB_ACC:
        add_y = ~opnd;
      ssod_pkg::OP_ADD_TO_Q,
      ssod_pkg::OP_INCREASE_Q:
        add_x = q_reg;
      ssod_pkg::OP_REPLACE_ADD_ONE:
      begin
        add_x = opnd;
        add_y = ssod_pkg::WORD_ONE;
      end
      default:
        add_x = acc_reg;
    endcase
  end

  ssod_oc_adder #(
    .WIDTH (ssod_pkg::DATA_W)
  ) u_adder (
    .x   (add_x),
    .y   (add_y),
    .sum (add_sum),
    .ovf (add_ovf)
  );

  assign sh_left = (op == ssod_pkg::OP_SHIFT_ACC_LEFT)
                || (op == ssod_pkg::OP_SHIFT_Q_LEFT)
                || (op == ssod_pkg::OP_SHIFT_LONG_LEFT);

  ssod_shifter #(
    .WIDTH   (ssod_pkg::DATA_W),
    .COUNT_W (ssod_pkg::COUNT_W)
  ) u_sh_a (
    .value  (acc_reg),
    .count  (instr.count),
    .left   (sh_left),
    .result (sh_a_res)
  );

  ssod_shifter #(
    .WIDTH   (ssod_pkg::DATA_W),
    .COUNT_W (ssod_pkg::COUNT_W)
  ) u_sh_q (
    .value  (q_reg),
    .count  (instr.count),
    .left   (sh_left),
    .result (sh_q_res)
  );

  // A is the upper half of the long register
  ssod_shifter #(
    .WIDTH   (2 * ssod_pkg::DATA_W),
    .COUNT_W (ssod_pkg::COUNT_W)
  ) u_sh_aq (
    .value  ({acc_reg, q_reg}),
    .count  (instr.count),
    .left   (sh_left),
    .result (sh_aq_res)
  );

  always_comb
  begin
    acc_next       = acc_reg;
    q_next         = q_reg;
    overflow_next  = overflow_reg;
    skip_next      = 1'b0;
    done_next      = op_valid;
    mem_wr_next    = 1'b0;
    mem_wdata_next = mem_wdata_reg;
    if (op_valid)
    begin
      case (op)
        ssod_pkg::OP_ENTER_ACC_IMMEDIATE,
        ssod_pkg::OP_LOAD_ACC:
          acc_next = opnd;
        ssod_pkg::OP_ENTER_Q_IMMEDIATE,
        ssod_pkg::OP_LOAD_Q:
          q_next = opnd;
        ssod_pkg::OP_STORE_Q:
        begin
          mem_wr_next    = 1'b1;
          mem_wdata_next = q_reg;
        end
        ssod_pkg::OP_AND_ACC:
          acc_next = acc_reg & opnd;
        ssod_pkg::OP_EXCLUSIVE_OR_ACC:
          acc_next = acc_reg ^ opnd;
        // sticky: only the skip on overflow and skip on no overflow ops clear it
        ssod_pkg::OP_ADD_ACC,
        ssod_pkg::OP_SUB_ACC,
        ssod_pkg::OP_INCREASE_ACC:
        begin
          acc_next      = add_sum;
          overflow_next = overflow_reg | add_ovf;
        end
        ssod_pkg::OP_ADD_TO_Q,
        ssod_pkg::OP_INCREASE_Q:
        begin
          q_next        = add_sum;
          overflow_next = overflow_reg | add_ovf;
        end
        ssod_pkg::OP_REPLACE_ADD_ONE:
        begin
          mem_wr_next    = 1'b1;
          mem_wdata_next = add_sum;
          overflow_next  = overflow_reg | add_ovf;
        end
        ssod_pkg::OP_SKIP_ACC_POS_ZERO:
          skip_next = (acc_reg == ssod_pkg::POS_ZERO);
        ssod_pkg::OP_SKIP_ACC_NONZERO:
          skip_next = (acc_reg != ssod_pkg::POS_ZERO);
        ssod_pkg::OP_SKIP_ACC_POSITIVE:
          skip_next = ~acc_reg[ssod_pkg::SIGN_BIT];
        ssod_pkg::OP_SKIP_ACC_NEGATIVE:
          skip_next = acc_reg[ssod_pkg::SIGN_BIT];
        ssod_pkg::OP_SKIP_Q_POS_ZERO:
          skip_next = (q_reg == ssod_pkg::POS_ZERO);
        ssod_pkg::OP_SKIP_Q_NONZERO:
          skip_next = (q_reg != ssod_pkg::POS_ZERO);
        ssod_pkg::OP_SKIP_Q_POSITIVE:
          skip_next = ~q_reg[ssod_pkg::SIGN_BIT];
        ssod_pkg::OP_SKIP_Q_NEGATIVE:
          skip_next = q_reg[ssod_pkg::SIGN_BIT];
        ssod_pkg::OP_SKIP_ON_OVERFLOW:
        begin
          skip_next     = overflow_reg;
          overflow_next = 1'b0;
        end
        ssod_pkg::OP_SKIP_ON_NO_OVERFLOW:
        begin
          skip_next     = ~overflow_reg;
          overflow_next = 1'b0;
        end
        // shifts leave the overflow indicator alone
        ssod_pkg::OP_SHIFT_ACC_LEFT,
        ssod_pkg::OP_SHIFT_ACC_RIGHT:
          acc_next = sh_a_res;
        ssod_pkg::OP_SHIFT_Q_LEFT,
        ssod_pkg::OP_SHIFT_Q_RIGHT:
          q_next = sh_q_res;
        ssod_pkg::OP_SHIFT_LONG_LEFT,
        ssod_pkg::OP_SHIFT_LONG_RIGHT:
        begin
          acc_next = sh_aq_res[31:16];
          q_next   = sh_aq_res[15:0];
        end
        default:
          done_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      acc_reg       <= ssod_pkg::ACC_RST;
      q_reg         <= ssod_pkg::Q_RST;
      overflow_reg  <= ssod_pkg::OVF_RST;
      skip_reg      <= 1'b0;
      done_reg      <= 1'b0;
      mem_wr_reg    <= 1'b0;
      mem_wdata_reg <= ssod_pkg::WDATA_RST;
    end
    else
    begin
      acc_reg       <= acc_next;
      q_reg         <= q_next;
      overflow_reg  <= overflow_next;
      skip_reg      <= skip_next;
      done_reg      <= done_next;
      mem_wr_reg    <= mem_wr_next;
      mem_wdata_reg <= mem_wdata_next;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence s_go(ssod_pkg::ssod_op_t o);
    op_valid && op == o;
  endsequence

  chk_pos_zero_skip: assert property (
    s_go(ssod_pkg::OP_SKIP_ACC_POS_ZERO)
    |=> skip_reg == ($past(acc_reg) == 16'h0000))
    else $error("pos-zero skip wrong");

  chk_neg_zero_noskip: assert property (
    s_go(ssod_pkg::OP_SKIP_ACC_POS_ZERO) ##0 acc_reg == 16'hffff
    |=> !skip_reg)
    else $error("negative zero skipped as zero");

  chk_nonzero_skip: assert property (
    s_go(ssod_pkg::OP_SKIP_ACC_NONZERO)
    |=> skip_reg == ($past(acc_reg) != 16'h0000))
    else $error("nonzero skip wrong");

  chk_sign_skip: assert property (
    s_go(ssod_pkg::OP_SKIP_ACC_NEGATIVE)
    |=> skip_reg == $past(acc_reg[15]) && acc_reg == $past(acc_reg))
    else $error("negative skip wrong");

  chk_q_match: assert property (
    s_go(ssod_pkg::OP_SKIP_Q_NONZERO) ##0 q_reg == acc_reg
    |=> skip_reg == ($past(acc_reg) != 16'h0000))
    else $error("Q test differs from A test");

  chk_shift_no_ovf: assert property (
    op_valid && sh_left
    |=> overflow_reg == $past(overflow_reg))
    else $error("left shift changed overflow");

  chk_right_one: assert property (
    s_go(ssod_pkg::OP_SHIFT_ACC_RIGHT) ##0 instr.count == 5'h01
    |=> acc_reg == {$past(acc_reg[15]), $past(acc_reg[15:1])})
    else $error("single right shift wrong");

  chk_long_right: assert property (
    s_go(ssod_pkg::OP_SHIFT_LONG_RIGHT) ##0 instr.count == 5'h01
    |=> q_reg[15] == $past(acc_reg[0]))
    else $error("long right did not feed Q");

  chk_enter_acc: assert property (
    s_go(ssod_pkg::OP_ENTER_ACC_IMMEDIATE) ##1 !op_valid
    |-> acc_reg == $past(opnd) ##1 acc_reg == $past(acc_reg))
    else $error("enter did not load A");

  chk_and_acc: assert property (
    s_go(ssod_pkg::OP_AND_ACC) ##0 acc_reg == 16'hffff
    |=> acc_reg == $past(opnd))
    else $error("AND result wrong");

  chk_sov_clear: assert property (
    s_go(ssod_pkg::OP_SKIP_ON_OVERFLOW)
    |=> !overflow_reg && skip_reg == $past(overflow_reg))
    else $error("skip on overflow did not clear");

  sequence s_sno_pair;
    s_go(ssod_pkg::OP_SKIP_ON_NO_OVERFLOW)
    ##1 s_go(ssod_pkg::OP_SKIP_ON_NO_OVERFLOW);
  endsequence

  chk_sno_twice: assert property (
    s_sno_pair |=> skip_reg && !overflow_reg)
    else $error("second no-overflow skip missed");

  chk_store_q: assert property (
    s_go(ssod_pkg::OP_STORE_Q)
    |=> mem_wr_reg && mem_wdata_reg == $past(q_reg))
    else $error("store Q data wrong");

endmodule : ssod_datapath

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] q;
    logic        ovf;
    logic        skip;
    logic        wr;
    logic [15:0] wdata;
  } ssod_note_t;

  logic                  mclk;
  logic                  rstn;
  logic                  op_valid;
  ssod_pkg::ssod_instr_t instr;
  logic [15:0]           acc_reg;
  logic [15:0]           q_reg;
  logic                  overflow_reg;
  logic                  skip_reg;
  logic                  done_reg;
  logic                  mem_wr_reg;
  logic [15:0]           mem_wdata_reg;
  ssod_note_t            notes[$];
  ssod_note_t            n;
  ssod_note_t            m;
  ssod_pkg::ssod_op_t    mix[14];
  logic [15:0]           vals[6];
  integer                seed;
  int                    miscompares;
  int                    check_count;

  ssod_datapath dut (
    .mclk          (mclk),
    .rstn          (rstn),
    .op_valid      (op_valid),
    .instr         (instr),
    .acc_reg       (acc_reg),
    .q_reg         (q_reg),
    .overflow_reg  (overflow_reg),
    .skip_reg      (skip_reg),
    .done_reg      (done_reg),
    .mem_wr_reg    (mem_wr_reg),
    .mem_wdata_reg (mem_wdata_reg)
  );

  always #20 mclk = ~mclk;

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one's complement sum with end-around carry, overflow in bit 16
  function automatic logic [16:0] oc_sum(input logic [15:0] x, y);
    logic [16:0] s;
    logic [15:0] r;
    s = {1'b0, x} + {1'b0, y};
    r = s[15:0] + {15'h0000, s[16]};
    oc_sum = {(x[15] == y[15]) && (r[15] != x[15]), r};
  endfunction : oc_sum

  // drives one instruction and notes what the registers must show after it
  task automatic issue(input ssod_pkg::ssod_op_t op, input logic [15:0] d,
                       input logic [4:0] c);
    logic [16:0] r;
    logic [63:0] t;
    @(posedge mclk);
    #1;
    op_valid = 1'b1;
    instr    = '{op, d, c};
    m.skip   = 1'b0;
    m.wr     = 1'b0;
    r        = 17'h00000;
    case (op)
      ssod_pkg::OP_ENTER_ACC_IMMEDIATE, ssod_pkg::OP_LOAD_ACC: m.a = d;
      ssod_pkg::OP_ENTER_Q_IMMEDIATE, ssod_pkg::OP_LOAD_Q: m.q = d;
      ssod_pkg::OP_STORE_Q: {m.wr, m.wdata} = {1'b1, m.q};
      ssod_pkg::OP_AND_ACC: m.a = m.a & d;
      ssod_pkg::OP_EXCLUSIVE_OR_ACC: m.a = m.a ^ d;
      ssod_pkg::OP_ADD_ACC, ssod_pkg::OP_INCREASE_ACC: r = oc_sum(m.a, d);
      ssod_pkg::OP_SUB_ACC: r = oc_sum(m.a, ~d);
      ssod_pkg::OP_ADD_TO_Q, ssod_pkg::OP_INCREASE_Q: r = oc_sum(m.q, d);
      ssod_pkg::OP_REPLACE_ADD_ONE: r = oc_sum(d, 16'h0001);
      ssod_pkg::OP_SKIP_ACC_POS_ZERO: m.skip = (m.a == 16'h0000);
      ssod_pkg::OP_SKIP_ACC_NONZERO: m.skip = (m.a != 16'h0000);
      ssod_pkg::OP_SKIP_ACC_POSITIVE: m.skip = ~m.a[15];
      ssod_pkg::OP_SKIP_ACC_NEGATIVE: m.skip = m.a[15];
      ssod_pkg::OP_SKIP_Q_POS_ZERO: m.skip = (m.q == 16'h0000);
      ssod_pkg::OP_SKIP_Q_NONZERO: m.skip = (m.q != 16'h0000);
      ssod_pkg::OP_SKIP_Q_POSITIVE: m.skip = ~m.q[15];
      ssod_pkg::OP_SKIP_Q_NEGATIVE: m.skip = m.q[15];
      ssod_pkg::OP_SKIP_ON_OVERFLOW: {m.skip, m.ovf} = {m.ovf, 1'b0};
      ssod_pkg::OP_SKIP_ON_NO_OVERFLOW: {m.skip, m.ovf} = {~m.ovf, 1'b0};
      ssod_pkg::OP_SHIFT_ACC_LEFT: t = {m.a, m.a, 32'h00000000} << c[3:0];
      ssod_pkg::OP_SHIFT_Q_LEFT: t = {m.q, m.q, 32'h00000000} << c[3:0];
      ssod_pkg::OP_SHIFT_ACC_RIGHT: m.a = $signed(m.a) >>> c;
      ssod_pkg::OP_SHIFT_Q_RIGHT: m.q = $signed(m.q) >>> c;
      ssod_pkg::OP_SHIFT_LONG_LEFT: t = {m.a, m.q, m.a, m.q} << c;
      ssod_pkg::OP_SHIFT_LONG_RIGHT: {m.a, m.q} = $signed({m.a, m.q}) >>> c;
      default: ;
    endcase
    case (op)
      ssod_pkg::OP_ADD_ACC, ssod_pkg::OP_INCREASE_ACC,
      ssod_pkg::OP_SUB_ACC: m.a = r[15:0];
      ssod_pkg::OP_ADD_TO_Q, ssod_pkg::OP_INCREASE_Q: m.q = r[15:0];
      ssod_pkg::OP_REPLACE_ADD_ONE: {m.wr, m.wdata} = {1'b1, r[15:0]};
      ssod_pkg::OP_SHIFT_ACC_LEFT: m.a = t[63:48];
      ssod_pkg::OP_SHIFT_Q_LEFT: m.q = t[63:48];
      ssod_pkg::OP_SHIFT_LONG_LEFT: {m.a, m.q} = t[63:32];
      default: ;
    endcase
    m.ovf = m.ovf | r[16];
    notes.push_back(m);
  endtask : issue

  task automatic idle(input string name);
    @(posedge mclk);
    #1;
    op_valid = 1'b0;
    repeat (3) @(posedge mclk);
    $display("test %s finished", name);
  endtask : idle

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // result watcher: one note per completed instruction
  always @(negedge mclk)
  begin
    if (rstn && done_reg === 1'b1)
    begin
      if (notes.size() == 0)
        check("unexpected done", 16'h0001, 16'h0000);
      else
      begin
        n = notes.pop_front();
        check("acc", acc_reg, n.a);
        check("q", q_reg, n.q);
        check("overflow", {15'h0000, overflow_reg}, {15'h0000, n.ovf});
        check("skip", {15'h0000, skip_reg}, {15'h0000, n.skip});
        check("mem_wr", {15'h0000, mem_wr_reg}, {15'h0000, n.wr});
        if (n.wr)
          check("wdata", mem_wdata_reg, n.wdata);
      end
    end
  end

  initial
  begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    summarize();
  end

  initial
  begin
    mclk     = 1'b0;
    rstn     = 1'b0;
    op_valid = 1'b0;
    instr    = '0;
    seed     = 91168;
    m        = '0;
    vals     = '{16'h0000, 16'hffff, 16'h4000, 16'h8000, 16'h0001, 16'h7fff};
    mix      = '{ssod_pkg::OP_AND_ACC, ssod_pkg::OP_ADD_ACC,
                 ssod_pkg::OP_SUB_ACC, ssod_pkg::OP_ADD_TO_Q,
                 ssod_pkg::OP_INCREASE_ACC, ssod_pkg::OP_INCREASE_Q,
                 ssod_pkg::OP_REPLACE_ADD_ONE, ssod_pkg::OP_EXCLUSIVE_OR_ACC,
                 ssod_pkg::OP_STORE_Q, ssod_pkg::OP_LOAD_ACC,
                 ssod_pkg::OP_LOAD_Q, ssod_pkg::OP_SKIP_ON_OVERFLOW,
                 ssod_pkg::OP_SKIP_ON_NO_OVERFLOW, ssod_pkg::OP_NOP};
    repeat (16) @(posedge mclk);
    #1;
    rstn = 1'b1;
    check("acc after reset", acc_reg, 16'h0000);
    check("wdata after reset", mem_wdata_reg, 16'h0000);
    // zero patterns of both signs and four other fixed values, then random operands, on the eight A and Q skips
    for (int i = 0; i < 14; i++)
    begin
      m.wdata = (i < 6) ? vals[i] : 16'($random(seed));
      issue(ssod_pkg::OP_ENTER_ACC_IMMEDIATE, m.wdata, 5'h00);
      issue(ssod_pkg::OP_ENTER_Q_IMMEDIATE, m.wdata, 5'h00);
      for (int k = 14; k < 22; k++)
        issue(ssod_pkg::ssod_op_t'(k), 16'h0000, 5'h00);
    end
    issue(ssod_pkg::OP_ENTER_ACC_IMMEDIATE, 16'($random(seed)), 5'h00);
    idle("skips");
    issue(ssod_pkg::OP_ENTER_ACC_IMMEDIATE, 16'h4000, 5'h00);
    repeat (15) issue(ssod_pkg::OP_SHIFT_ACC_RIGHT, 16'h0000, 5'h01);
    issue(ssod_pkg::OP_ENTER_ACC_IMMEDIATE, 16'h8000, 5'h00);
    issue(ssod_pkg::OP_ENTER_Q_IMMEDIATE, 16'h4000, 5'h00);
    repeat (31) issue(ssod_pkg::OP_SHIFT_LONG_RIGHT, 16'h0000, 5'h01);
    for (int k = 1; k < 32; k++)
    begin
      issue(ssod_pkg::OP_ENTER_ACC_IMMEDIATE, 16'($random(seed)), 5'h00);
      issue(ssod_pkg::OP_ENTER_Q_IMMEDIATE, 16'($random(seed)), 5'h00);
      issue(ssod_pkg::OP_SHIFT_LONG_LEFT, 16'h0000, 5'(k));
    end
    // single-register left and right shifts kept below one full turn of a register
    repeat (24) issue(ssod_pkg::ssod_op_t'(5'h18 + 5'($random(seed) & 3)),
                      16'h0000, 5'($random(seed) & 15));
    idle("shifts");
    // all-ones A so the AND result must equal the operand
    repeat (4)
    begin
      issue(ssod_pkg::OP_ENTER_ACC_IMMEDIATE, 16'hffff, 5'h00);
      issue(ssod_pkg::OP_AND_ACC, 16'($random(seed)), 5'h00);
    end
    repeat (300) issue(mix[$unsigned($random(seed)) % 14],
                       16'($random(seed)), 5'h00);
    idle("arithmetic");
    // forced sign flips both ways, each skip tested twice in a row
    for (int k = 0; k < 4; k++)
    begin
      issue(ssod_pkg::OP_ENTER_ACC_IMMEDIATE, k[0] ? 16'h8000 : 16'h7fff,
            5'h00);
      issue(ssod_pkg::OP_ADD_ACC, k[0] ? 16'hfffe : 16'h0001, 5'h00);
      repeat (2) issue(k[1] ? ssod_pkg::OP_SKIP_ON_NO_OVERFLOW
                            : ssod_pkg::OP_SKIP_ON_OVERFLOW,
                       16'h0000, 5'h00);
    end
    idle("overflow");
    check("pending notes", 16'(notes.size()), 16'h0000);
    summarize();
  end
endmodule : tb
